/* design/hbb_map.svh */
// Constants of the bridge buffer block: line geometry and field positions.
// Assumes inclusion by every design file that needs them; definitions only.
`ifndef HBB_MAP_SVH
`define HBB_MAP_SVH
// ----------------------------------------
// Line geometry
// ----------------------------------------
`define HBB_LINE_BEATS 4
`define HBB_HALF_BEATS 2
`define HBB_TAG_LSB 5
`define HBB_HALF_LSB 4
`define HBB_DW_LSB 3
// ----------------------------------------
// Defaults
// ----------------------------------------
`define HBB_SNOOP_DEPTH 4
`define HBB_ATTR_W 4
`endif

/* design/hbb_pkg.sv */
// Types shared by the bridge buffer block.
// Assumes hbb_map.svh constants are used alongside.
package hbb_pkg;
	// ----------------------------------------
	// Read buffer states, Gray along the usual path
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		RB_IDLE = 3'h0,
		RB_FETCH = 3'h1,
		RB_REARB = 3'h5,
		RB_HOLD = 3'h3,
		RB_RETURN = 3'h2
	} hbb_rb_state_t;
endpackage

/* design/hbb_copyback.sv */
// Copy-back line buffer: snoop copy-backs and ECC burst writes parked toward memory.
// Assumes fill beats arrive in line order, first beat marked.
`timescale 1ns/100ps
`include "hbb_map.svh"
module hbb_copyback
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Fill side
	input wire logic ecc_enable,
	input wire logic fill_valid,
	input wire logic fill_first,
	input wire logic [31:0] fill_addr,
	input wire logic [63:0] fill_data,
	// Address compare
	input wire logic cmp_valid,
	input wire logic cmp_pci,
	input wire logic [31:0] cmp_addr,
	output logic cmp_hit,
	// Flush side
	input wire logic mem_free,
	input wire logic flush_ack,
	output logic flush_req,
	output logic flush_urgent,
	output logic [31:0] flush_addr,
	output logic [63:0] flush_data,
	output logic [7:0] flush_ecc,
	output logic flush_last,
	output logic cb_valid
);
	logic [63:0] line [0:`HBB_LINE_BEATS-1];
	logic [26:0] tag;
	logic [1:0] fill_idx;
	logic [1:0] out_idx;
	logic urgent;
	wire [1:0] wr_idx = fill_first ? 2'h0 : fill_idx;

	// ----------------------------------------
	// Compare, flush and check codes
	// ----------------------------------------
	assign cmp_hit = cb_valid && cmp_valid && (cmp_addr[31:`HBB_TAG_LSB] == tag);
	assign flush_req = cb_valid && (mem_free || urgent);
	assign flush_urgent = cb_valid && urgent;
	assign flush_addr = {tag, out_idx, 3'h0};
	assign flush_data = line[out_idx];
	assign flush_last = (out_idx == 2'h3);
	genvar b;
	generate
		for (b = 0; b < 8; b = b + 1)
		begin : g_ecc
			assign flush_ecc[b] = ecc_enable & (^line[out_idx][8*b +: 8]);
		end
	endgenerate

	always_ff @(posedge clock)
	begin
		if (fill_valid)
			line[wr_idx] <= fill_data;
	end

	// Valid rises only once the last beat is in; a fill started while valid keeps valid high over a part line
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			cb_valid <= 1'b0;
			tag <= 27'h0;
			fill_idx <= 2'h0;
			out_idx <= 2'h0;
			urgent <= 1'b0;
		end
		else
		begin
			if (cmp_hit && cmp_pci)
				urgent <= 1'b1;
			if (flush_req && flush_ack)
			begin
				out_idx <= out_idx + 2'h1;
				if (flush_last)
				begin
					cb_valid <= 1'b0;
					urgent <= 1'b0;
				end
			end
			// A line completing as the old one leaves must stay valid
			if (fill_valid)
			begin
				fill_idx <= wr_idx + 2'h1;
				if (fill_first)
					tag <= fill_addr[31:`HBB_TAG_LSB];
				if (wr_idx == 2'h3)
					cb_valid <= 1'b1;
			end
		end
	end
endmodule // hbb_copyback

/* design/hbb_write_bufs.sv */
// Two half-line posted write buffers from the processor toward the PCI bus.
// Assumes burst writes come as four doubleword beats, line order.
`timescale 1ns/100ps
`include "hbb_map.svh"
module hbb_write_bufs
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Processor write side
	input wire logic store_gather_enable,
	input wire logic wr_valid,
	input wire logic wr_burst,
	input wire logic wr_io,
	input wire logic wr_sync,
	input wire logic [31:0] wr_addr,
	input wire logic [63:0] wr_data,
	input wire logic [7:0] wr_be,
	output logic wr_ready,
	// PCI master write side
	input wire logic pci_wr_ack,
	output logic pci_wr_req,
	output logic pci_wr_io,
	output logic pci_wr_last,
	output logic [31:0] pci_wr_addr,
	output logic [63:0] pci_wr_data,
	output logic [7:0] pci_wr_be
);
	logic [63:0] dat [0:3];
	logic [7:0] be [0:3];
	logic [27:0] baddr [0:1];
	logic [1:0] bv;
	logic [1:0] bio;
	logic [1:0] closed;
	logic head;
	logic tail;
	logic burst_mode;
	logic filling;
	logic [1:0] fill_cnt;
	logic [1:0] out_cnt;

	// ----------------------------------------
	// Slot choice and gathering
	// ----------------------------------------
	wire empty = (bv == 2'h0);
	wire slot = empty ? head : ~tail;
	wire space = empty || !bv[~tail];
	wire can_gather = store_gather_enable && !wr_io && !wr_burst && bv[tail] && (tail != head) &&
		!closed[tail] && !bio[tail] && (wr_addr[31:`HBB_HALF_LSB] == baddr[tail]);
	// A burst always opens at buffer 0, wherever head was left
	wire dst_buf = filling ? fill_cnt[1] : (can_gather ? tail : (wr_burst ? 1'b0 : slot));
	wire dst_dw = filling ? fill_cnt[0] : (!wr_burst && wr_addr[`HBB_DW_LSB]);
	wire [1:0] dst = {dst_buf, dst_dw};
	wire keep_old = can_gather && !filling;
	wire accept = wr_valid && wr_ready;
	wire [1:0] out_idx = burst_mode ? out_cnt : {head, out_cnt[0]};
	logic [63:0] merged;
	genvar b;
	generate
		for (b = 0; b < 8; b = b + 1)
		begin : g_merge
			assign merged[8*b +: 8] = wr_be[b] ? wr_data[8*b +: 8] : (keep_old ? dat[dst][8*b +: 8] : 8'h00);
		end
	endgenerate

	// Posting: ready depends on buffer space only, never on PCI completion
	assign wr_ready = filling || (wr_burst ? empty : (can_gather || space));
	assign pci_wr_req = bv[head] && !filling;
	assign pci_wr_io = bio[head];
	assign pci_wr_addr = {baddr[burst_mode ? 1'b0 : head], 4'h0};
	assign pci_wr_data = dat[out_idx];
	assign pci_wr_be = be[out_idx];
	assign pci_wr_last = burst_mode ? (out_cnt == 2'h3) : out_cnt[0];

	always_ff @(posedge clock)
	begin
		if (accept)
			dat[dst] <= merged;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 4; i++)
				be[i] <= 8'h00;
			baddr[0] <= 28'h0;
			baddr[1] <= 28'h0;
			bv <= 2'h0;
			bio <= 2'h0;
			closed <= 2'h0;
			head <= 1'b0;
			tail <= 1'b0;
			burst_mode <= 1'b0;
			filling <= 1'b0;
			fill_cnt <= 2'h0;
			out_cnt <= 2'h0;
		end
		else
		begin
			if (pci_wr_req && pci_wr_ack)
			begin
				out_cnt <= out_cnt + 2'h1;
				if (pci_wr_last)
				begin
					out_cnt <= 2'h0;
					if (burst_mode)
						bv <= 2'h0;
					else
					begin
						bv[head] <= 1'b0;
						closed[head] <= 1'b0;
						head <= ~head;
					end
					burst_mode <= 1'b0;
				end
			end
			if (wr_sync)
				closed <= bv;
			if (accept)
			begin
				be[dst] <= keep_old ? (be[dst] | wr_be) : wr_be;
				if (filling)
				begin
					fill_cnt <= fill_cnt + 2'h1;
					if (fill_cnt == 2'h3)
					begin
						filling <= 1'b0;
						bv <= 2'h3;
					end
				end
				else if (wr_burst)
				begin
					filling <= 1'b1;
					fill_cnt <= 2'h1;
					burst_mode <= 1'b1;
					head <= 1'b0;
					tail <= 1'b1;
					baddr[0] <= wr_addr[31:`HBB_HALF_LSB];
					bio <= {wr_io, wr_io};
				end
				else if (!can_gather)
				begin
					bv[slot] <= 1'b1;
					bio[slot] <= wr_io;
					closed[slot] <= 1'b0;
					baddr[slot] <= wr_addr[31:`HBB_HALF_LSB];
					tail <= slot;
				end
			end
		end
	end
endmodule // hbb_write_bufs

/* design/hbb_ccu_buffers.sv */
// Central buffer control of the host bridge: read buffer, snoop order, buffer glue.
// Assumes one clock for processor, PCI and memory sides; partners hold requests level.
`timescale 1ns/100ps
`include "hbb_map.svh"
module hbb_ccu_buffers
#(
	parameter int SNOOP_DEPTH = `HBB_SNOOP_DEPTH
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Configuration
	input wire logic snoop_disable,
	input wire logic store_gather_enable,
	input wire logic ecc_enable,
	// Processor read from PCI
	input wire logic proc_rd_valid,
	input wire logic proc_rd_burst,
	input wire logic [31:0] proc_rd_addr,
	input wire logic [`HBB_ATTR_W-1:0] proc_rd_attr,
	output logic proc_rd_retry,
	output logic proc_rd_dvalid,
	output logic proc_rd_done,
	output logic [63:0] proc_rd_data,
	// Processor write to PCI
	input wire logic proc_wr_valid,
	input wire logic proc_wr_burst,
	input wire logic proc_wr_io,
	input wire logic proc_wr_sync,
	input wire logic [31:0] proc_wr_addr,
	input wire logic [63:0] proc_wr_data,
	input wire logic [7:0] proc_wr_be,
	output logic proc_wr_ready,
	// Processor access to system memory
	input wire logic proc_mem_valid,
	input wire logic [31:0] proc_mem_addr,
	input wire logic proc_bw_valid,
	input wire logic proc_bw_first,
	input wire logic [63:0] proc_bw_data,
	output logic proc_lock_blocked,
	output logic proc_cb_hit,
	// PCI master read
	input wire logic pci_rd_gnt,
	input wire logic pci_rd_dvalid,
	input wire logic pci_rd_disc,
	input wire logic [63:0] pci_rd_data,
	output logic pci_rd_req,
	output logic [31:0] pci_rd_addr,
	// PCI master write
	input wire logic pci_wr_ack,
	output logic pci_wr_req,
	output logic pci_wr_io,
	output logic pci_wr_last,
	output logic [31:0] pci_wr_addr,
	output logic [63:0] pci_wr_data,
	output logic [7:0] pci_wr_be,
	// PCI target access to system memory
	input wire logic pci_mem_valid,
	input wire logic pci_mem_write,
	input wire logic pci_mem_lock,
	input wire logic pci_unlock,
	input wire logic [31:0] pci_mem_addr,
	output logic pci_mem_ready,
	output logic pci_mem_retry,
	output logic pci_cb_hit,
	output logic pci_proc_conflict,
	output logic pci_fwd_valid,
	output logic [63:0] pci_fwd_data,
	// Snoop toward the processor core
	input wire logic snoop_ack,
	input wire logic snoop_cb_valid,
	input wire logic snoop_cb_first,
	input wire logic [63:0] snoop_cb_data,
	output logic snoop_req,
	output logic snoop_write,
	output logic snoop_lock,
	output logic [31:0] snoop_addr,
	// Copy-back flush to memory
	input wire logic mem_free,
	input wire logic mem_flush_ack,
	output logic mem_flush_req,
	output logic mem_flush_urgent,
	output logic mem_flush_last,
	output logic [31:0] mem_flush_addr,
	output logic [63:0] mem_flush_data,
	output logic [7:0] mem_flush_ecc
);
	localparam int QW = $clog2(SNOOP_DEPTH);
	if (SNOOP_DEPTH < 2 || (1 << QW) != SNOOP_DEPTH)
	begin : g_bad_depth
		$error("SNOOP_DEPTH must be a power of two, at least 2");
	end

	// ----------------------------------------
	// Snoop queue: strict arrival order
	// ----------------------------------------
	logic [31:0] sq_addr [0:SNOOP_DEPTH-1];
	logic [SNOOP_DEPTH-1:0] sq_write;
	logic [SNOOP_DEPTH-1:0] sq_lock;
	logic [QW-1:0] sq_rd;
	logic [QW-1:0] sq_wr;
	logic [QW:0] sq_cnt;
	logic [QW:0] wr_snoops;
	hbb_pkg::hbb_rb_state_t rb_state;
	hbb_pkg::hbb_rb_state_t next_rb_state;

	wire sq_full = (sq_cnt == SNOOP_DEPTH[QW:0]);
	wire wr_blocked = (rb_state == hbb_pkg::RB_HOLD) && (wr_snoops != '0);
	assign pci_mem_retry = pci_mem_valid && pci_mem_write && wr_blocked;
	assign pci_mem_ready = !sq_full;
	// With snooping off the access is taken but never queued
	wire sq_push = pci_mem_valid && !pci_mem_retry && !sq_full && !snoop_disable;
	assign snoop_req = (sq_cnt != '0) && !snoop_disable;
	wire sq_pop = snoop_req && snoop_ack;
	assign snoop_addr = sq_addr[sq_rd];
	assign snoop_write = sq_write[sq_rd];
	assign snoop_lock = sq_lock[sq_rd];

	always_ff @(posedge clock)
	begin
		if (sq_push)
			sq_addr[sq_wr] <= pci_mem_addr;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			sq_write <= '0;
			sq_lock <= '0;
			sq_rd <= '0;
			sq_wr <= '0;
			sq_cnt <= '0;
			wr_snoops <= '0;
		end
		else
		begin
			if (sq_push)
			begin
				sq_write[sq_wr] <= pci_mem_write;
				sq_lock[sq_wr] <= pci_mem_lock && !pci_mem_write;
				sq_wr <= sq_wr + 1'b1;
			end
			if (sq_pop)
				sq_rd <= sq_rd + 1'b1;
			sq_cnt <= sq_cnt + QW'(0) + (sq_push ? 1'b1 : 1'b0) - (sq_pop ? 1'b1 : 1'b0);
			wr_snoops <= wr_snoops + (sq_push && pci_mem_write ? 1'b1 : 1'b0)
				- (sq_pop && snoop_write ? 1'b1 : 1'b0);
		end
	end

	// ----------------------------------------
	// Lock, processor address buffer, copy-back compare
	// ----------------------------------------
	logic lock_valid;
	logic [26:0] lock_tag;
	logic [26:0] proc_mem_tag;
	logic proc_mem_seen;
	assign proc_lock_blocked = lock_valid && !snoop_disable && proc_mem_valid &&
		(proc_mem_addr[31:`HBB_TAG_LSB] == lock_tag);
	assign pci_proc_conflict = pci_mem_valid && proc_mem_seen &&
		(pci_mem_addr[31:`HBB_TAG_LSB] == proc_mem_tag);

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			lock_valid <= 1'b0;
			lock_tag <= 27'h0;
			proc_mem_tag <= 27'h0;
			proc_mem_seen <= 1'b0;
		end
		else
		begin
			if (sq_push && pci_mem_lock && !pci_mem_write)
			begin
				lock_valid <= 1'b1;
				lock_tag <= pci_mem_addr[31:`HBB_TAG_LSB];
			end
			else if (pci_unlock)
				lock_valid <= 1'b0;
			if (proc_mem_valid)
			begin
				proc_mem_seen <= 1'b1;
				proc_mem_tag <= proc_mem_addr[31:`HBB_TAG_LSB];
			end
		end
	end

	wire cb_hit;
	wire cmp_pci = pci_mem_valid;
	wire [31:0] cmp_addr = pci_mem_valid ? pci_mem_addr : proc_mem_addr;
	wire cb_fill = snoop_cb_valid || (ecc_enable && proc_bw_valid);
	wire cb_first = snoop_cb_valid ? snoop_cb_first : proc_bw_first;
	wire [31:0] cb_addr = snoop_cb_valid ? snoop_addr : proc_mem_addr;
	wire [63:0] cb_data = snoop_cb_valid ? snoop_cb_data : proc_bw_data;
	assign pci_cb_hit = pci_mem_valid && cb_hit;
	assign proc_cb_hit = !pci_mem_valid && cb_hit;

	hbb_copyback u_copyback
	(
		.clock(clock),
		.rstn(rstn),
		.ecc_enable(ecc_enable),
		.fill_valid(cb_fill),
		.fill_first(cb_first),
		.fill_addr(cb_addr),
		.fill_data(cb_data),
		.cmp_valid(pci_mem_valid || proc_mem_valid),
		.cmp_pci(cmp_pci),
		.cmp_addr(cmp_addr),
		.cmp_hit(cb_hit),
		.mem_free(mem_free),
		.flush_ack(mem_flush_ack),
		.flush_req(mem_flush_req),
		.flush_urgent(mem_flush_urgent),
		.flush_addr(mem_flush_addr),
		.flush_data(mem_flush_data),
		.flush_ecc(mem_flush_ecc),
		.flush_last(mem_flush_last),
		.cb_valid()
	);

	// ----------------------------------------
	// Copy-back capture toward PCI read
	// ----------------------------------------
	logic [63:0] b2m_line [0:`HBB_LINE_BEATS-1];
	logic [1:0] b2m_in;
	logic [1:0] b2m_out;
	logic b2m_full;
	// Forwarding waits for the whole copy-back; a new copy-back's first beat during forwarding stops it part way
	wire b2m_take = snoop_cb_valid && !snoop_write;

	always_ff @(posedge clock)
	begin
		if (b2m_take)
			b2m_line[snoop_cb_first ? 2'h0 : b2m_in] <= snoop_cb_data;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			b2m_in <= 2'h0;
			b2m_out <= 2'h0;
			b2m_full <= 1'b0;
			pci_fwd_valid <= 1'b0;
			pci_fwd_data <= 64'h0;
		end
		else
		begin
			pci_fwd_valid <= b2m_full;
			pci_fwd_data <= b2m_line[b2m_out];
			if (b2m_take)
			begin
				b2m_in <= (snoop_cb_first ? 2'h0 : b2m_in) + 2'h1;
				b2m_full <= snoop_cb_first ? 1'b0 : (b2m_in == 2'h3);
			end
			else if (b2m_full)
			begin
				b2m_out <= b2m_out + 2'h1;
				b2m_full <= (b2m_out != 2'h3);
			end
		end
	end

	// ----------------------------------------
	// Processor read from PCI
	// ----------------------------------------
	logic [63:0] rd_line [0:`HBB_LINE_BEATS-1];
	logic [31:0] rd_addr;
	logic [`HBB_ATTR_W-1:0] rd_attr;
	logic rd_burst;
	logic [2:0] rcv;
	logic [1:0] out_beat;
	logic retried;
	logic next_retry;

	wire [2:0] need = rd_burst ? 3'h4 : 3'h1;
	wire [31:0] rd_base = rd_burst ? {rd_addr[31:`HBB_TAG_LSB], 5'h0} : {rd_addr[31:`HBB_DW_LSB], 3'h0};
	wire [1:0] cap_idx = rd_burst ? rcv[1:0] : rd_addr[4:3];
	wire [1:0] ret_idx = rd_addr[4:3] + out_beat;
	wire last_cap = pci_rd_dvalid && (rcv + 3'h1 == need);
	wire same_req = proc_rd_valid && (proc_rd_addr == rd_addr) && (proc_rd_attr == rd_attr) &&
		(proc_rd_burst == rd_burst);
	wire snoops_clear = (wr_snoops == '0);
	wire ret_last = rd_burst ? (out_beat == 2'h3) : 1'b1;
	assign pci_rd_req = (rb_state == hbb_pkg::RB_FETCH) || (rb_state == hbb_pkg::RB_REARB);
	assign pci_rd_addr = rd_base + {26'h0, rcv, 3'h0};

	always_comb
	begin
		next_rb_state = rb_state;
		next_retry = 1'b0;
		case (rb_state)
			hbb_pkg::RB_IDLE:
				if (proc_rd_valid)
					next_rb_state = hbb_pkg::RB_FETCH;
			hbb_pkg::RB_FETCH:
				if (last_cap)
					next_rb_state = hbb_pkg::RB_HOLD;
				else if (pci_rd_disc)
					next_rb_state = hbb_pkg::RB_REARB;
			hbb_pkg::RB_REARB:
			begin
				next_retry = pci_mem_valid || (retried && proc_rd_valid);
				if (pci_rd_gnt)
					next_rb_state = hbb_pkg::RB_FETCH;
			end
			hbb_pkg::RB_HOLD:
				if (!retried && snoops_clear)
					next_rb_state = hbb_pkg::RB_RETURN;
				else if (retried && proc_rd_valid)
				begin
					next_retry = !(same_req && snoops_clear);
					if (same_req && snoops_clear)
						next_rb_state = hbb_pkg::RB_RETURN;
				end
			hbb_pkg::RB_RETURN:
				if (ret_last)
					next_rb_state = hbb_pkg::RB_IDLE;
			default:
				next_rb_state = hbb_pkg::RB_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rb_state == hbb_pkg::RB_FETCH && pci_rd_dvalid)
			rd_line[cap_idx] <= pci_rd_data;
	end

	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			rb_state <= hbb_pkg::RB_IDLE;
			rd_addr <= 32'h0;
			rd_attr <= '0;
			rd_burst <= 1'b0;
			rcv <= 3'h0;
			out_beat <= 2'h0;
			retried <= 1'b0;
			proc_rd_retry <= 1'b0;
			proc_rd_dvalid <= 1'b0;
			proc_rd_done <= 1'b0;
			proc_rd_data <= 64'h0;
		end
		else
		begin
			rb_state <= next_rb_state;
			proc_rd_retry <= next_retry;
			proc_rd_dvalid <= (rb_state == hbb_pkg::RB_RETURN);
			proc_rd_done <= (rb_state == hbb_pkg::RB_RETURN) && ret_last;
			proc_rd_data <= rd_line[ret_idx];
			if (next_retry)
				retried <= 1'b1;
			if (rb_state == hbb_pkg::RB_IDLE && proc_rd_valid)
			begin
				rd_addr <= proc_rd_addr;
				rd_attr <= proc_rd_attr;
				rd_burst <= proc_rd_burst;
				rcv <= 3'h0;
				retried <= 1'b0;
			end
			if (rb_state == hbb_pkg::RB_FETCH && pci_rd_dvalid)
				rcv <= rcv + 3'h1;
			if (rb_state == hbb_pkg::RB_HOLD && next_rb_state == hbb_pkg::RB_RETURN)
			begin
				out_beat <= 2'h0;
				retried <= 1'b0;
			end
			if (rb_state == hbb_pkg::RB_RETURN)
				out_beat <= out_beat + 2'h1;
		end
	end

	// ----------------------------------------
	// Processor writes to PCI
	// ----------------------------------------
	hbb_write_bufs u_write_bufs
	(
		.clock(clock),
		.rstn(rstn),
		.store_gather_enable(store_gather_enable),
		.wr_valid(proc_wr_valid),
		.wr_burst(proc_wr_burst),
		.wr_io(proc_wr_io),
		.wr_sync(proc_wr_sync),
		.wr_addr(proc_wr_addr),
		.wr_data(proc_wr_data),
		.wr_be(proc_wr_be),
		.wr_ready(proc_wr_ready),
		.pci_wr_ack(pci_wr_ack),
		.pci_wr_req(pci_wr_req),
		.pci_wr_io(pci_wr_io),
		.pci_wr_last(pci_wr_last),
		.pci_wr_addr(pci_wr_addr),
		.pci_wr_data(pci_wr_data),
		.pci_wr_be(pci_wr_be)
	);
endmodule // hbb_ccu_buffers

/* bench/hbb_pci_model.sv */
// Far side of the bridge buffers: PCI target for reads and writes.
// Assumes the bridge holds pci_rd_req and pci_wr_req level until served.
`timescale 1ns/100ps
module hbb_pci_model
(
	// Clock and reset
	input wire logic clock,
	input wire logic rstn,
	// Test control
	input wire logic wr_slow,
	input wire logic [2:0] disc_at,
	// Read side
	input wire logic pci_rd_req,
	input wire logic [31:0] pci_rd_addr,
	output logic pci_rd_gnt,
	output logic pci_rd_dvalid,
	output logic pci_rd_disc,
	output logic [63:0] pci_rd_data,
	// Write side
	input wire logic pci_wr_req,
	output logic pci_wr_ack
);
	logic on;
	logic go;
	logic tick;
	logic [2:0] beats;
	logic [31:0] at;
	assign pci_rd_gnt = on;
	// Stop part way when asked, so the bridge must come back for the rest
	assign pci_rd_disc = go && pci_rd_req && disc_at != 3'h0 && beats == disc_at;
	assign pci_rd_dvalid = go && pci_rd_req && !pci_rd_disc;
	// Idle data lines never show the last beat, an unknown must not pass
	assign pci_rd_data = pci_rd_dvalid ? {~at, at} : {at, ~at};
	assign pci_wr_ack = pci_wr_req && (tick || !wr_slow);
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			on <= 1'b0;
			go <= 1'b0;
			tick <= 1'b0;
			beats <= 3'h0;
			at <= 32'h0;
		end
		else
		begin
			tick <= !tick;
			go <= on && pci_rd_req && !pci_rd_disc;
			if (pci_rd_disc || !pci_rd_req)
				on <= 1'b0;
			else if (!on)
			begin
				on <= 1'b1;
				at <= pci_rd_addr;
				beats <= 3'h0;
			end
			else if (pci_rd_dvalid)
			begin
				at <= at + 32'h8;
				beats <= beats + 3'h1;
			end
		end
	end
endmodule // hbb_pci_model

/* bench/hbb_ccu_checker.sv */
// Port assertions of the bridge buffer control.
// Assumes binding onto hbb_ccu_buffers, one clock.
`timescale 1ns/100ps
module hbb_ccu_checker
(
	input wire logic clock, rstn, snoop_disable, proc_lock_blocked,
	input wire logic pci_wr_req, pci_wr_ack, pci_rd_req, pci_rd_dvalid, pci_rd_disc,
	input wire logic snoop_req, snoop_ack, proc_wr_valid, proc_wr_burst, proc_wr_ready,
	input wire logic proc_rd_done, proc_rd_dvalid,
	input wire logic [31:0] pci_wr_addr, snoop_addr
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	chk_lock_ignored: assert property (snoop_disable |-> !proc_lock_blocked)
		else $error("lock blocks with snooping off");
	chk_no_new_snoop: assert property (snoop_disable |-> !snoop_req)
		else $error("snoop issued while disabled");
	chk_wr_posted: assert property (pci_wr_req && !pci_wr_ack |=> pci_wr_req && $stable(pci_wr_addr))
		else $error("posted write dropped or moved");
	chk_rd_tenure: assert property (pci_rd_req && !pci_rd_dvalid && !pci_rd_disc |=> pci_rd_req)
		else $error("read request dropped early");
	chk_snoop_order: assert property (snoop_req && !snoop_ack |=> snoop_req && $stable(snoop_addr))
		else $error("snoop head changed before ack");
	chk_burst_waits: assert property (proc_wr_valid && proc_wr_burst && pci_wr_req |-> !proc_wr_ready)
		else $error("burst accepted with writes pending");
	chk_done_beat: assert property (proc_rd_done |-> proc_rd_dvalid)
		else $error("done without data beat");
	chk_data_after_fetch: assert property (proc_rd_dvalid |-> !pci_rd_req)
		else $error("data returned while still fetching");
endmodule // hbb_ccu_checker

/* bench/hbb_ccu_buffers_tb.sv */
// Self-checking bench of the bridge buffer control with a PCI target model.
// Assumes design and checker files compiled before it.
`timescale 1ns/100ps
`include "hbb_map.svh"
module hbb_ccu_buffers_tb;
	logic clock=0, rstn=0, snoop_disable=0, store_gather_enable=0, ecc_enable=0, proc_rd_valid=0, proc_rd_burst=0;
	logic proc_wr_valid=0, proc_wr_burst=0, proc_wr_io=0, proc_wr_sync=0, proc_mem_valid=0, proc_bw_valid=0;
	logic proc_bw_first=0, pci_mem_valid=0, pci_mem_write=0, pci_mem_lock=0, pci_unlock=0, snoop_ack=0;
	logic snoop_cb_valid=0, snoop_cb_first=0, mem_free=1, mem_flush_ack=0, wr_slow=0;
	logic [31:0] proc_rd_addr=0, proc_wr_addr=0, proc_mem_addr=0, pci_mem_addr=0;
	logic [63:0] proc_wr_data=0, proc_bw_data=0, snoop_cb_data=0;
	logic [7:0] proc_wr_be=0;
	logic [`HBB_ATTR_W-1:0] proc_rd_attr=0;
	logic [2:0] disc_at=0;
	logic proc_rd_retry, proc_rd_dvalid, proc_rd_done, proc_wr_ready, proc_lock_blocked, proc_cb_hit;
	logic pci_rd_req, pci_rd_gnt, pci_rd_dvalid, pci_rd_disc, pci_wr_ack, pci_wr_req, pci_wr_io, pci_wr_last;
	logic pci_mem_ready, pci_mem_retry, pci_cb_hit, pci_proc_conflict, pci_fwd_valid;
	logic snoop_req, snoop_write, snoop_lock, mem_flush_req, mem_flush_urgent, mem_flush_last;
	logic [31:0] pci_rd_addr, pci_wr_addr, snoop_addr, mem_flush_addr, rnd=32'h4acb73ed, a, sa[3];
	logic [63:0] proc_rd_data, pci_rd_data, pci_wr_data, pci_fwd_data, mem_flush_data, dd[6], wq[$];
	logic [7:0] pci_wr_be, mem_flush_ecc;
	int err_total=0, checks_done=0, i, n, t;
	hbb_ccu_buffers #(.SNOOP_DEPTH(4)) i_hbb_ccu_buffers (.*);
	hbb_pci_model i_hbb_pci_model (.*);
	always #20 clock = ~clock;
	always @(posedge clock)
		if (pci_wr_req && pci_wr_ack && pci_wr_be != 8'h0)
			wq.push_back(pci_wr_data);
	function automatic logic [31:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction
	task summarize();
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic await(ref logic s);
		int k;
		for (k = 0; k < 300 && s !== 1'b1; k++)
			@(negedge clock);
		if (k == 300)
		begin
			err_total++;
			summarize();
		end
	endtask
	// Issue a read, expect critical doubleword first with wrap in the line
	task automatic rd(input bit b, input logic [31:0] ad, input logic [2:0] d);
		logic [31:0] x;
		disc_at = d;
		proc_rd_burst = b;
		proc_rd_addr = ad;
		proc_rd_attr = 4'(xs());
		proc_rd_valid = 1;
		@(negedge clock);
		proc_rd_valid = 0;
		for (int k = 0; k < (b ? 4 : 1); k++)
		begin
			x = b ? {ad[31:5], 2'(ad[4:3] + k), 3'h0} : ad;
			await(proc_rd_dvalid);
			chk("read data", {~x, x}, proc_rd_data);
			chk("read done", 64'(k == (b ? 3 : 0)), 64'(proc_rd_done));
			@(negedge clock);
		end
		repeat (2) @(negedge clock);
	endtask
	task automatic wb(input logic [31:0] ad, input logic [63:0] d, input bit b, input bit io);
		proc_wr_valid = 1;
		proc_wr_burst = b;
		proc_wr_io = io;
		proc_wr_addr = ad;
		proc_wr_data = d;
		proc_wr_be = 8'hff;
		await(proc_wr_ready);
		@(negedge clock);
	endtask
	initial
	begin
		repeat (20) @(negedge clock);
		rstn = 1;
		@(negedge clock);
		for (i = 0; i < 10; i++)
			rd(1, (xs() & 32'h7fff_ffe0) | ((i == 0 ? 32'h1 : xs() & 32'h3) << 3), i == 0 ? 3'h2 : 3'(xs() & 32'h3));
		rd(0, xs() & 32'h7fff_fff8, 3'h0);
		// Write snoops queued ahead of a read hold its data back
		pci_mem_write = 1;
		for (i = 0; i < 3; i++)
		begin
			sa[i] = xs() & 32'h7fff_ffe0;
			pci_mem_addr = sa[i];
			pci_mem_valid = 1;
			@(negedge clock);
		end
		pci_mem_valid = 0;
		proc_rd_burst = 0;
		proc_rd_addr = 32'h100;
		proc_rd_valid = 1;
		@(negedge clock);
		proc_rd_valid = 0;
		n = 0;
		repeat (15) begin @(negedge clock); n += 32'(proc_rd_dvalid); end
		chk("early data", 64'h0, 64'(n));
		pci_mem_valid = 1;
		#1 chk("write retried", 64'h1, 64'(pci_mem_retry));
		pci_mem_valid = 0;
		for (i = 0; i < 3; i++)
		begin
			await(snoop_req);
			chk("snoop addr", 64'(sa[i]), 64'(snoop_addr));
			snoop_ack = 1;
			@(negedge clock);
			snoop_ack = 0;
		end
		proc_rd_valid = 1;
		@(negedge clock);
		proc_rd_valid = 0;
		await(proc_rd_dvalid);
		chk("held read data", {~32'h100, 32'h100}, proc_rd_data);
		repeat (3) @(negedge clock);
		// Disconnect, then a PCI memory access: processor retried, asks again
		disc_at = 3'h1;
		proc_rd_burst = 1;
		proc_rd_addr = 32'h200;
		proc_rd_valid = 1;
		@(negedge clock);
		proc_rd_valid = 0;
		await(pci_rd_disc);
		pci_mem_write = 0;
		pci_mem_valid = 1;
		await(proc_rd_retry);
		chk("read retried", 64'h1, 64'(proc_rd_retry));
		pci_mem_valid = 0;
		snoop_ack = 1;
		repeat (4) @(negedge clock);
		snoop_ack = 0;
		proc_rd_valid = 1;
		await(proc_rd_dvalid);
		proc_rd_valid = 0;
		chk("retried read", {~32'h200, 32'h200}, proc_rd_data);
		repeat (6) @(negedge clock);
		// Locked read blocks the line; snooping off lifts it and queues nothing
		pci_mem_lock = 1;
		pci_mem_valid = 1;
		proc_mem_valid = 1;
		proc_mem_addr = pci_mem_addr;
		@(negedge clock);
		pci_mem_valid = 0;
		chk("lock held", 64'h1, 64'(proc_lock_blocked));
		chk("snoop lock", 64'h1, 64'(snoop_lock));
		snoop_ack = 1;
		@(negedge clock);
		snoop_ack = 0;
		snoop_disable = 1;
		pci_mem_valid = 1;
		@(negedge clock);
		pci_mem_valid = 0;
		repeat (3) @(negedge clock);
		chk("snoop off", 64'h0, 64'(snoop_req));
		chk("lock ignored", 64'h0, 64'(proc_lock_blocked));
		snoop_disable = 0;
		pci_mem_lock = 0;
		proc_mem_valid = 0;
		// Two singles in one half line, then a burst behind them
		wr_slow = 1;
		store_gather_enable = 1'(xs());
		a = xs() & 32'h7fff_ffe0;
		for (i = 0; i < 6; i++)
			dd[i] = {xs(), xs()};
		wb(a, dd[0], 0, 0);
		chk("write posted", 64'h1, 64'(proc_wr_ready));
		wb(a + 32'h8, dd[1], 0, 1);
		for (i = 0; i < 4; i++)
			wb(a + 32'(8 * i), dd[2 + i], 1, 0);
		proc_wr_valid = 0;
		for (t = 0; t < 300 && wq.size() < 6; t++)
			@(negedge clock);
		chk("write beats", 64'h6, 64'(wq.size()));
		for (i = 0; i < 6 && i < wq.size(); i++)
			chk("write data", dd[i], wq[i]);
		summarize();
	end
endmodule // hbb_ccu_buffers_tb
bind hbb_ccu_buffers hbb_ccu_checker i_hbb_ccu_checker (.*);
